/* logic/exw_regs.svh */
// constants for the exception entry and wakeup block
`ifndef EXW_REGS_SVH
`define EXW_REGS_SVH
`define EXW_NUM_IRQ 20
`define EXW_FRAME_WORDS 4'h8
`define EXW_WORD_BYTES 32'h00000004
`define EXW_SP_RESET 32'h20001000
`define EXW_PRIO_LOWEST 2'h3
`define EXW_VTB_LSB 28
`define EXW_WDT_IRQ 5'h00
`endif

/* logic/exw_pkg.sv */
// types for the exception entry and wakeup block
package exw_pkg;
    typedef enum logic [4:0] {
        EXW_RUN = 5'h01,
        EXW_PUSH = 5'h02,
        EXW_HANDLER = 5'h04,
        EXW_POP = 5'h08,
        EXW_LOWPWR = 5'h10
    } exw_state_t;
    typedef enum logic [1:0] {
        EXW_ACTIVE = 2'h0,
        EXW_SLEEP = 2'h1,
        EXW_DEEPSLEEP = 2'h2
    } exw_power_t;
    typedef struct packed {
        logic write;
        logic [31:0] addr;
        logic [31:0] data;
    } exw_mem_t;
    typedef struct packed {
        logic [19:0] setEnable;
        logic [19:0] clearEnable;
        logic [19:0] setPending;
        logic [19:0] clearPending;
    } exw_irq_wr_t;
endpackage

/* logic/exw_exception_entry.sv */
// exception entry, stacking, return and wakeup control
`timescale 1ns/1ps
`include "exw_regs.svh"
module exw_exception_entry (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [19:0] irqLines,
    input wire exw_pkg::exw_irq_wr_t irqWrite,
    input wire logic [39:0] irqPriority,
    input wire logic globalPriorityMask,
    input wire logic stackSelect,
    input wire logic waitForIrq,
    input wire logic deepSleepSel,
    input wire logic handlerReturn,
    input wire logic [31:0] vectorTableBase,
    input wire logic [255:0] coreRegs,
    input wire logic [31:0] popData,
    output exw_pkg::exw_mem_t memReq,
    output logic [31:0] handlerAddr,
    output logic [4:0] activeIrq,
    output logic handlerMode,
    output logic [19:0] enableStatus,
    output logic [19:0] pendingStatus,
    output logic [255:0] restoredRegs,
    output logic restoreDone,
    output logic wakeup,
    output exw_pkg::exw_power_t powerState,
    output logic [31:0] mainStackPointer,
    output logic [31:0] processStackPointer
);
    exw_pkg::exw_state_t state_reg, state_next;
    logic [19:0] irqMeta_reg, irqSync_reg, irqPrev_reg;
    logic [19:0] enable_reg, pending_reg;
    logic [3:0] count_reg;
    logic useProcess_reg; // stack that received the frame
    logic [4:0] irqNum;
    logic found;
    logic [1:0] bestPrio;
    logic [19:0] ready, irqRise, wakeSrc;
    logic useProcessNow, anyWake;
    logic [31:0] curSp, nextSp;

    // word index in the frame; slot 0 is r0 at the lowest address
    function automatic logic [31:0] frameWord(input logic [255:0] regs, input logic [3:0] idx);
        frameWord = regs[{idx[2:0], 5'h00} +: 32];
    endfunction

    // three flops on the asynchronous peripheral request lines
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            irqMeta_reg <= 20'h00000;
            irqSync_reg <= 20'h00000;
            irqPrev_reg <= 20'h00000;
        end
        else
        begin
            irqMeta_reg <= irqLines;
            irqSync_reg <= irqMeta_reg;
            irqPrev_reg <= irqSync_reg;
        end
    end

    // only enabled, unmasked pending lines may be taken
    assign irqRise = irqSync_reg & ~irqPrev_reg;
    assign ready = pending_reg & enable_reg & {20{~globalPriorityMask}};
    // watchdog alone survives deep sleep
    assign wakeSrc = (powerState == exw_pkg::EXW_DEEPSLEEP) ?
        (irqSync_reg & enable_reg & (20'h00001 << `EXW_WDT_IRQ)) :
        (irqSync_reg & enable_reg);
    assign anyWake = |wakeSrc;

    // lowest level wins, lowest number breaks ties
    always_comb
    begin
        irqNum = 5'h00;
        found = 1'b0;
        bestPrio = `EXW_PRIO_LOWEST;
        for (int i = 0; i < `EXW_NUM_IRQ; i++)
        begin
            if (ready[i] && (!found || irqPriority[2*i +: 2] < bestPrio))
            begin
                found = 1'b1;
                bestPrio = irqPriority[2*i +: 2];
                irqNum = 5'(i);
            end
        end
    end

    // handler mode forces the main pointer; thread mode uses the select bit
    assign useProcessNow = (state_reg == exw_pkg::EXW_HANDLER) ? 1'b0 : stackSelect;
    assign curSp = useProcess_reg ? processStackPointer : mainStackPointer;
    assign nextSp = (state_reg == exw_pkg::EXW_PUSH) ?
        curSp - `EXW_WORD_BYTES : curSp + `EXW_WORD_BYTES;

    // sequencer for entry, handler, return and low power
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            exw_pkg::EXW_RUN:
                if (found)
                    state_next = exw_pkg::EXW_PUSH;
                else if (waitForIrq)
                    state_next = exw_pkg::EXW_LOWPWR;
            exw_pkg::EXW_PUSH:
                if (count_reg == `EXW_FRAME_WORDS - 4'h1)
                    state_next = exw_pkg::EXW_HANDLER;
            exw_pkg::EXW_HANDLER:
                if (handlerReturn)
                    state_next = exw_pkg::EXW_POP;
            exw_pkg::EXW_POP:
                if (count_reg == `EXW_FRAME_WORDS - 4'h1)
                    state_next = exw_pkg::EXW_RUN;
            exw_pkg::EXW_LOWPWR:
                if (anyWake)
                    state_next = exw_pkg::EXW_RUN;
            default:
                state_next = exw_pkg::EXW_RUN;
        endcase
    end

    // state, counters and stack pointers
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= exw_pkg::EXW_RUN;
            count_reg <= 4'h0;
            useProcess_reg <= 1'b0;
            mainStackPointer <= `EXW_SP_RESET;
            processStackPointer <= `EXW_SP_RESET;
        end
        else
        begin
            state_reg <= state_next;
            count_reg <= (state_next == state_reg) ? count_reg + 4'h1 : 4'h0;
            if (state_reg == exw_pkg::EXW_RUN && found)
                useProcess_reg <= useProcessNow;
            if (state_reg == exw_pkg::EXW_PUSH || state_reg == exw_pkg::EXW_POP)
            begin
                if (useProcess_reg)
                    processStackPointer <= nextSp;
                else
                    mainStackPointer <= nextSp;
            end
        end
    end

    // memory side: push r0 last so the pointer ends on it; pop in reverse
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            memReq <= '0;
            restoredRegs <= '0;
            restoreDone <= 1'b0;
        end
        else
        begin
            memReq.write <= (state_reg == exw_pkg::EXW_PUSH);
            memReq.addr <= (state_reg == exw_pkg::EXW_POP) ? curSp : nextSp;
            // frame order top-down: status, return, link, r12, r3, r2, r1, r0
            memReq.data <= frameWord(coreRegs, 4'h7 - count_reg);
            if (state_reg == exw_pkg::EXW_POP)
                restoredRegs[{count_reg[2:0], 5'h00} +: 32] <= popData;
            restoreDone <= (state_reg == exw_pkg::EXW_POP) && (state_next == exw_pkg::EXW_RUN);
        end
    end

    // enable and pending bits; only ones in a write act
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            enable_reg <= 20'h00000;
            pending_reg <= 20'h00000;
            activeIrq <= 5'h00;
            handlerAddr <= 32'h00000000;
        end
        else
        begin
            enable_reg <= (enable_reg | irqWrite.setEnable) & ~irqWrite.clearEnable;
            // set beats clear; the one in-service line is retired on entry
            pending_reg <= ((pending_reg & ~irqWrite.clearPending)
                | irqWrite.setPending | (irqRise & enable_reg))
                & ~((state_reg == exw_pkg::EXW_RUN && found) ?
                    (20'h00001 << irqNum) : 20'h00000);
            if (state_reg == exw_pkg::EXW_RUN && found)
            begin
                activeIrq <= irqNum;
                // six bits: vector numbers above 31 must not wrap
                handlerAddr <= {vectorTableBase[31:`EXW_VTB_LSB], 28'h0000000}
                    + {24'h000000, 6'(irqNum) + 6'h10, 2'h0};
            end
        end
    end

    // status and power outputs
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            handlerMode <= 1'b0;
            enableStatus <= 20'h00000;
            pendingStatus <= 20'h00000;
            wakeup <= 1'b0;
            powerState <= exw_pkg::EXW_ACTIVE;
        end
        else
        begin
            handlerMode <= (state_next == exw_pkg::EXW_HANDLER) || (state_next == exw_pkg::EXW_POP);
            enableStatus <= enable_reg;
            pendingStatus <= pending_reg;
            wakeup <= (state_reg == exw_pkg::EXW_LOWPWR) && anyWake;
            if (state_reg == exw_pkg::EXW_RUN && !found && waitForIrq)
                powerState <= deepSleepSel ? exw_pkg::EXW_DEEPSLEEP : exw_pkg::EXW_SLEEP;
            else if (state_reg == exw_pkg::EXW_LOWPWR && anyWake)
                powerState <= exw_pkg::EXW_ACTIVE;
        end
    end
endmodule

/* sim/exw_props.sv */
// port assertions for the exception entry block
`timescale 1ns/1ps
module exw_props (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [255:0] coreRegs,
    input wire logic stackSelect,
    input wire logic globalPriorityMask,
    input wire logic waitForIrq,
    input wire exw_pkg::exw_mem_t memReq,
    input wire logic handlerMode,
    input wire logic restoreDone,
    input wire logic wakeup,
    input wire exw_pkg::exw_power_t powerState,
    input wire logic [31:0] mainStackPointer,
    input wire logic [31:0] processStackPointer
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // push burst, frame order and placement
    AST_PUSH8: assert property ($rose(memReq.write) |-> memReq.write[*8] ##1 !memReq.write)
        else $error("push burst length wrong");
    AST_FRAME: assert property ($rose(memReq.write) |-> memReq.data == coreRegs[255:224]
        ##7 memReq.data == coreRegs[31:0]) else $error("frame order wrong");
    AST_DOWN: assert property (memReq.write && $past(memReq.write) |->
        memReq.addr == $past(memReq.addr) - 32'h4) else $error("stack not growing down");
    AST_SPSEL: assert property ($rose(memReq.write) |-> ##7 memReq.addr ==
        (stackSelect ? processStackPointer : mainStackPointer)) else $error("wrong stack");
    AST_LATE: assert property ($rose(memReq.write) |-> (!handlerMode)[*7] ##[1:3] handlerMode)
        else $error("handler mode timing wrong");
    AST_RESTORE: assert property (restoreDone |=> !restoreDone && !handlerMode)
        else $error("restore end wrong");
    // mask and power behaviour
    AST_MASK: assert property (globalPriorityMask[*3] |-> !$rose(memReq.write))
        else $error("masked irq taken");
    AST_WAKE: assert property (wakeup |=> !wakeup && powerState == exw_pkg::EXW_ACTIVE)
        else $error("wakeup not to active");
    AST_SLEEP: assert property (powerState != exw_pkg::EXW_ACTIVE &&
        $past(powerState) == exw_pkg::EXW_ACTIVE |-> $past(waitForIrq)) else $error("sleep cause");
endmodule
bind exw_exception_entry exw_props exw_props_i (.clk_sys, .resetn, .coreRegs, .stackSelect,
    .globalPriorityMask, .waitForIrq, .memReq, .handlerMode, .restoreDone, .wakeup,
    .powerState, .mainStackPointer, .processStackPointer);

/* sim/exw_stack_mem.sv */
// stack memory model behind the push and pop port
`timescale 1ns/1ps
module exw_stack_mem (
    input wire logic clk_sys,
    input wire exw_pkg::exw_mem_t memReq,
    input wire logic usePsp,
    input wire logic [31:0] mainStackPointer,
    input wire logic [31:0] processStackPointer,
    output logic [31:0] popData
);
    // 64 words span the frames below the reset pointer; upper address bits ignored
    logic [31:0] mem [0:63];
    wire [31:0] rdAddr = usePsp ? processStackPointer : mainStackPointer;
    // unwritten places read a pattern tied to the slot, never plain zero
    initial
        for (int k = 0; k < 64; k++)
            mem[k] = 32'hdead0000 + 32'(k);
    // frame words land where the block points
    always @(posedge clk_sys)
        if (memReq.write)
            mem[memReq.addr[7:2]] <= memReq.data;
    // pops read the word at the chosen pointer in the same cycle
    assign popData = mem[rdAddr[7:2]];
endmodule

/* sim/tb_exception_entry_and_wakeup.sv */
// self-checking bench for the exception entry and wakeup block
`timescale 1ns/1ps
`include "exw_regs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_exception_entry_and_wakeup;
    logic clk_sys = 1'h0, resetn = 1'h0, globalPriorityMask = 1'h0, stackSelect = 1'h0;
    logic waitForIrq = 1'h0, deepSleepSel = 1'h0, handlerReturn = 1'h0;
    logic handlerMode, restoreDone, wakeup;
    logic [19:0] irqLines = 20'h0, enableStatus, pendingStatus;
    logic [39:0] irqPriority = 40'hffffff3fff;
    // table base in sram so vectors may change at run time
    logic [31:0] vectorTableBase = 32'h20000000;
    logic [31:0] popData, handlerAddr;
    logic [31:0] mainStackPointer, processStackPointer;
    logic [255:0] coreRegs, restoredRegs;
    logic [4:0] activeIrq;
    exw_pkg::exw_irq_wr_t irqWrite = 80'h0;
    exw_pkg::exw_mem_t memReq;
    exw_pkg::exw_power_t powerState;
    int err_total = 0, checks = 0, i;
    exw_exception_entry exw_exception_entry_i (.clk_sys, .resetn, .irqLines, .irqWrite,
        .irqPriority, .globalPriorityMask, .stackSelect, .waitForIrq, .deepSleepSel,
        .handlerReturn, .vectorTableBase, .coreRegs, .popData, .memReq, .handlerAddr,
        .activeIrq, .handlerMode, .enableStatus, .pendingStatus, .restoredRegs, .restoreDone,
        .wakeup, .powerState, .mainStackPointer, .processStackPointer);
    exw_stack_mem exw_stack_mem_i (.clk_sys, .memReq, .usePsp(stackSelect),
        .mainStackPointer, .processStackPointer, .popData);
    // 250 MHz core clock
    initial
        forever #2 clk_sys = ~clk_sys;
    task automatic pulse(input exw_pkg::exw_irq_wr_t w);
        @(posedge clk_sys) irqWrite <= w;
        @(posedge clk_sys) irqWrite <= 80'h0;
        repeat (2) @(negedge clk_sys);
    endtask
    // one-cycle pulse on handler return (0) or wait-for-irq (1)
    task automatic strobe(input logic wait_for_irq_instruction);
        @(posedge clk_sys);
        if (wait_for_irq_instruction)
            waitForIrq <= 1'h1;
        else
            handlerReturn <= 1'h1;
        @(posedge clk_sys);
        waitForIrq <= 1'h0;
        handlerReturn <= 1'h0;
        @(negedge clk_sys);
    endtask
    // watched level: 0 handler mode, 1 restore done, 2 wakeup
    function automatic logic watched(input int sel);
        watched = (sel == 0) ? handlerMode : (sel == 1) ? restoreDone : wakeup;
    endfunction
    // bounded wait; running out is counted as a mismatch
    task automatic waitHi(input int sel);
        for (int k = 0; k < 40 && watched(sel) !== 1'h1; k++)
            @(negedge clk_sys);
        `CHK("wait", 1'h1, watched(sel))
    endtask
    task automatic service(input logic [4:0] n, input logic ps);
        waitHi(0);
        `CHK("irq", n, activeIrq)
        `CHK("vec", {vectorTableBase[31:28], 28'h0} + {n, 2'h0} + 32'h40, handlerAddr)
        `CHK("sp", `EXW_SP_RESET - 32'h20, ps ? processStackPointer : mainStackPointer)
        `CHK("msp", ps ? `EXW_SP_RESET : 32'h20000fe0, mainStackPointer)
        `CHK("top", coreRegs[255:224], exw_stack_mem_i.mem[6'((`EXW_SP_RESET - 32'h4) >> 2)])
        strobe(1'h0);
        waitHi(1);
        `CHK("regs", coreRegs, restoredRegs)
        `CHK("spback", `EXW_SP_RESET, ps ? processStackPointer : mainStackPointer)
    endtask
    task automatic final_report;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // expected run is a few hundred cycles
    initial
    begin
        #20000;
        err_total++;
        final_report();
    end
    initial
    begin
        for (i = 0; i < 8; i++)
            coreRegs[i*32 +: 32] = 32'h5a000000 + i;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'h1;
        @(negedge clk_sys);
        `CHK("psp", `EXW_SP_RESET, processStackPointer)
        // base, priority set above, then enable
        pulse({20'h9c, 60'h0});
        pulse({20'h0, 20'h10, 40'h0});
        `CHK("en", 20'h8c, enableStatus)
        pulse({40'h0, 20'h8, 20'h0});
        service(5'h3, 1'h0);
        // mask held so the second set lands on a line that is already pending
        @(posedge clk_sys);
        stackSelect <= 1'h1;
        globalPriorityMask <= 1'h1;
        pulse({40'h0, 20'h8, 20'h0});
        pulse({40'h0, 20'h8, 20'h0});
        `CHK("pend", 20'h8, pendingStatus)
        @(posedge clk_sys);
        globalPriorityMask <= 1'h0;
        service(5'h3, 1'h1);
        repeat (20) @(negedge clk_sys);
        `CHK("once", 1'h0, handlerMode)
        @(posedge clk_sys);
        stackSelect <= 1'h0;
        globalPriorityMask <= 1'h1;
        pulse({40'h0, 20'h84, 20'h0});
        repeat (20) @(negedge clk_sys);
        `CHK("mask", 21'h84, {handlerMode, pendingStatus})
        @(posedge clk_sys);
        globalPriorityMask <= 1'h0;
        service(5'h7, 1'h0);
        service(5'h2, 1'h0);
        // sleep, then wake from an enabled line
        pulse({20'h11, 60'h0});
        strobe(1'h1);
        `CHK("slp", exw_pkg::EXW_SLEEP, powerState)
        @(posedge clk_sys);
        irqLines <= 20'h10;
        waitHi(2);
        `CHK("wake", exw_pkg::EXW_ACTIVE, powerState)
        service(5'h4, 1'h0);
        @(posedge clk_sys);
        irqLines <= 20'h0;
        deepSleepSel <= 1'h1;
        strobe(1'h1);
        @(posedge clk_sys);
        irqLines <= 20'h10;
        repeat (10) @(negedge clk_sys);
        `CHK("deep", exw_pkg::EXW_DEEPSLEEP, powerState)
        @(posedge clk_sys);
        irqLines <= 20'h11;
        waitHi(2);
        `CHK("wdt", exw_pkg::EXW_ACTIVE, powerState)
        final_report();
    end
endmodule
